// ### design/rx_mode_pkg.sv
// Register map, field layout and reset values for the receiver mode and detect bank
package rx_mode_pkg;
  localparam logic [11:0] ADDR_SYNC_WINDOW = 12'h128;
  localparam logic [11:0] ADDR_SYNC_PHASE = 12'h129;
  localparam logic [11:0] ADDR_SYNC_COUNT = 12'h12a;
  localparam logic [11:0] ADDR_APP_MODE = 12'h200;
  localparam logic [11:0] ADDR_DECIMATION = 12'h201;
  localparam logic [11:0] ADDR_OFFSET_TRIM = 12'h228;
  localparam logic [11:0] ADDR_FLAG_CONTROL = 12'h245;
  localparam logic [11:0] ADDR_UPPER_LOW = 12'h247;
  localparam logic [11:0] ADDR_UPPER_HIGH = 12'h248;

  localparam logic [7:0] RESET_APP_MODE = 8'h07;
  localparam logic [7:0] RESET_DECIMATION = 8'h00;
  localparam logic [7:0] RESET_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RESET_FLAG_CONTROL = 8'h00;
  localparam logic [7:0] RESET_UPPER_LOW = 8'h00;
  localparam logic [7:0] RESET_UPPER_HIGH = 8'h00;

  // Field positions
  localparam int QIGNORE_BIT = 5;
  localparam int FORCE_PINS_BIT = 3;
  localparam int FORCE_VALUE_BIT = 2;
  localparam int FLAG_ENABLE_BIT = 0;

  // Writable masks: reserved bits read as zero
  localparam logic [7:0] MASK_APP_MODE = 8'h2f;
  localparam logic [7:0] MASK_DECIMATION = 8'h07;
  localparam logic [7:0] MASK_FLAG_CONTROL = 8'h0d;
  localparam logic [7:0] MASK_UPPER_HIGH = 8'h1f;

  // Operating mode codes
  localparam logic [3:0] MODE_ONE_CHANNEL = 4'h1;
  localparam logic [3:0] MODE_TWO_CHANNELS = 4'h2;
  localparam logic [3:0] MODE_FOUR_CHANNELS = 4'h3;
  localparam logic [3:0] MODE_REQUANTIZER = 4'h7;
  localparam logic [3:0] MODE_RANGE_MONITOR = 4'h8;

  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [3:0] RESET_PHASE = 4'h0;
endpackage

// ### design/threshold_flag_channel.sv
// One channel of threshold flag generation with software forcing
`timescale 1ns/1ps
module threshold_flag_channel #(
  parameter int SAMPLE_W = 14
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic [12:0] upperThreshold,
  input wire logic flagEnable,
  input wire logic forcePins,
  input wire logic forceValue,
  output logic flagPin
);
  logic next_flagPin;
  logic [SAMPLE_W-1:0] magnitude;

  // Magnitude of signed sample, the 13 bits below its top bit compared with threshold
  always_comb begin
    magnitude = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
    if (forcePins) begin
      next_flagPin = forceValue; // see R6, see R7
    end else if (flagEnable) begin
      next_flagPin = (magnitude[SAMPLE_W-2 -: 13] > upperThreshold); // see R6
    end else begin
      next_flagPin = 1'b0;
    end
  end

  // Registered so the pin never glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      flagPin <= 1'b0;
    end else begin
      flagPin <= next_flagPin;
    end
  end
endmodule

// ### design/receiver_mode_and_detect_regs.sv
// Register bank for sync capture status, mode, decimation, offset and threshold flags
//
// What this block does
// R1 - Count captured sync events in an 8-bit read-only counter, plus one each.
// R2 - Report 4-bit divider phase at capture, half input clock per step.
// R3 - Decode 4-bit operating mode: channels 1/2/4, requantizer (reset), range monitor.
// R4 - Quadrature-ignore bit drops the quadrature output, leaving in-phase only.
// R5 - Add signed 8-bit offset trim to output samples, range +127 to -128.
// R6 - Force bit clear: flags from detection; set: flags from software value.
// R7 - While forcing, force-value bit drives both channels' flag pins.
// R8 - Decode 3-bit decimation: 000 by 1, 001 by 2, 010 by 4, 011 by 8.
`timescale 1ns/1ps
module receiver_mode_and_detect_regs #(
  parameter int SAMPLE_W = 14
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic syncCaptured,
  input wire logic [3:0] syncPhase,
  input wire logic [7:0] syncWindow,
  input wire logic [SAMPLE_W-1:0] sampleA,
  input wire logic [SAMPLE_W-1:0] sampleB,
  output logic [SAMPLE_W-1:0] trimmedA,
  output logic [SAMPLE_W-1:0] trimmedB,
  output logic [3:0] channelEnable,
  output logic requantizerEnable,
  output logic rangeMonitorEnable,
  output logic quadratureEnable,
  output logic [3:0] decimationFactor,
  output logic flagPinA,
  output logic flagPinB
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Saturating add of the signed trim; wrapping would flip full scale
  function automatic logic [SAMPLE_W-1:0] addTrim(input logic [SAMPLE_W-1:0] s,
                                                  input logic [7:0] t);
    logic signed [SAMPLE_W:0] sum;
    logic signed [SAMPLE_W:0] maxV;
    logic signed [SAMPLE_W:0] minV;
    maxV = (SAMPLE_W+1)'((1 << (SAMPLE_W-1)) - 1);
    minV = -maxV - (SAMPLE_W+1)'(1);
    sum = $signed({s[SAMPLE_W-1], s}) + (SAMPLE_W+1)'($signed(t));
    if (sum > maxV) begin
      addTrim = maxV[SAMPLE_W-1:0];
    end else if (sum < minV) begin
      addTrim = minV[SAMPLE_W-1:0];
    end else begin
      addTrim = sum[SAMPLE_W-1:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0] applicationMode, next_applicationMode;
  logic [7:0] decimationSelect, next_decimationSelect;
  logic [7:0] offsetTrim, next_offsetTrim;
  logic [7:0] flagControl, next_flagControl;
  logic [7:0] upperLow, next_upperLow;
  logic [7:0] upperHigh, next_upperHigh;

  // Writes land masked so reserved bits always read zero
  always_comb begin
    next_applicationMode = applicationMode;
    next_decimationSelect = decimationSelect;
    next_offsetTrim = offsetTrim;
    next_flagControl = flagControl;
    next_upperLow = upperLow;
    next_upperHigh = upperHigh;
    if (regWrite) begin
      case (regAddr)
        rx_mode_pkg::ADDR_APP_MODE: begin
          next_applicationMode = regWrData & rx_mode_pkg::MASK_APP_MODE;
        end
        rx_mode_pkg::ADDR_DECIMATION: begin
          next_decimationSelect = regWrData & rx_mode_pkg::MASK_DECIMATION;
        end
        rx_mode_pkg::ADDR_OFFSET_TRIM: begin
          next_offsetTrim = regWrData;
        end
        rx_mode_pkg::ADDR_FLAG_CONTROL: begin
          next_flagControl = regWrData & rx_mode_pkg::MASK_FLAG_CONTROL;
        end
        rx_mode_pkg::ADDR_UPPER_LOW: begin
          next_upperLow = regWrData;
        end
        rx_mode_pkg::ADDR_UPPER_HIGH: begin
          next_upperHigh = regWrData & rx_mode_pkg::MASK_UPPER_HIGH;
        end
        default: begin
          next_upperLow = upperLow;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      applicationMode <= rx_mode_pkg::RESET_APP_MODE;
      decimationSelect <= rx_mode_pkg::RESET_DECIMATION;
      offsetTrim <= rx_mode_pkg::RESET_OFFSET_TRIM;
      flagControl <= rx_mode_pkg::RESET_FLAG_CONTROL;
      upperLow <= rx_mode_pkg::RESET_UPPER_LOW;
      upperHigh <= rx_mode_pkg::RESET_UPPER_HIGH;
    end else begin
      applicationMode <= next_applicationMode;
      decimationSelect <= next_decimationSelect;
      offsetTrim <= next_offsetTrim;
      flagControl <= next_flagControl;
      upperLow <= next_upperLow;
      upperHigh <= next_upperHigh;
    end
  end

  // ------------------------------------------------------------
  // Sync capture status
  // ------------------------------------------------------------
  logic [7:0] syncCount, next_syncCount;
  logic [3:0] capturedPhase, next_capturedPhase;

  // Counter wraps at 255; phase held until the next capture
  always_comb begin
    next_syncCount = syncCount;
    next_capturedPhase = capturedPhase;
    if (syncCaptured) begin
      next_syncCount = syncCount + 8'h01; // see R1
      next_capturedPhase = syncPhase; // see R2
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      syncCount <= rx_mode_pkg::RESET_COUNT;
      capturedPhase <= rx_mode_pkg::RESET_PHASE;
    end else begin
      syncCount <= next_syncCount;
      capturedPhase <= next_capturedPhase;
    end
  end

  // ------------------------------------------------------------
  // Read port: data one cycle after the strobe
  // ------------------------------------------------------------
  logic [7:0] next_regRdData;

  // Unmapped addresses read zero
  always_comb begin
    next_regRdData = 8'h00;
    if (regRead) begin
      case (regAddr)
        rx_mode_pkg::ADDR_SYNC_WINDOW: begin
          next_regRdData = syncWindow;
        end
        rx_mode_pkg::ADDR_SYNC_PHASE: begin
          next_regRdData = {4'h0, capturedPhase}; // see R2
        end
        rx_mode_pkg::ADDR_SYNC_COUNT: begin
          next_regRdData = syncCount; // see R1
        end
        rx_mode_pkg::ADDR_APP_MODE: begin
          next_regRdData = applicationMode;
        end
        rx_mode_pkg::ADDR_DECIMATION: begin
          next_regRdData = decimationSelect;
        end
        rx_mode_pkg::ADDR_OFFSET_TRIM: begin
          next_regRdData = offsetTrim;
        end
        rx_mode_pkg::ADDR_FLAG_CONTROL: begin
          next_regRdData = flagControl;
        end
        rx_mode_pkg::ADDR_UPPER_LOW: begin
          next_regRdData = upperLow;
        end
        rx_mode_pkg::ADDR_UPPER_HIGH: begin
          next_regRdData = upperHigh;
        end
        default: begin
          next_regRdData = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // ------------------------------------------------------------
  // Mode, decimation and datapath outputs
  // ------------------------------------------------------------
  logic [3:0] next_channelEnable;
  logic next_requantizerEnable;
  logic next_rangeMonitorEnable;
  logic next_quadratureEnable;
  logic [3:0] next_decimationFactor;
  logic [SAMPLE_W-1:0] next_trimmedA;
  logic [SAMPLE_W-1:0] next_trimmedB;

  // Unlisted mode codes switch channel, requantizer and range monitor paths off rather than guess
  always_comb begin
    next_channelEnable = 4'h0;
    next_requantizerEnable = 1'b0;
    next_rangeMonitorEnable = 1'b0;
    case (applicationMode[3:0])
      rx_mode_pkg::MODE_ONE_CHANNEL: begin
        next_channelEnable = 4'h1; // see R3
      end
      rx_mode_pkg::MODE_TWO_CHANNELS: begin
        next_channelEnable = 4'h3; // see R3
      end
      rx_mode_pkg::MODE_FOUR_CHANNELS: begin
        next_channelEnable = 4'hf; // see R3
      end
      rx_mode_pkg::MODE_REQUANTIZER: begin
        next_requantizerEnable = 1'b1; // see R3
      end
      rx_mode_pkg::MODE_RANGE_MONITOR: begin
        next_rangeMonitorEnable = 1'b1; // see R3
      end
      default: begin
        next_channelEnable = 4'h0;
      end
    endcase
    next_quadratureEnable = ~applicationMode[rx_mode_pkg::QIGNORE_BIT]; // see R4
    case (decimationSelect[2:0])
      3'h0: begin
        next_decimationFactor = 4'h1; // see R8
      end
      3'h1: begin
        next_decimationFactor = 4'h2; // see R8
      end
      3'h2: begin
        next_decimationFactor = 4'h4; // see R8
      end
      3'h3: begin
        next_decimationFactor = 4'h8; // see R8
      end
      default: begin
        next_decimationFactor = 4'h1;
      end
    endcase
    next_trimmedA = addTrim(sampleA, offsetTrim); // see R5
    next_trimmedB = addTrim(sampleB, offsetTrim); // see R5
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      channelEnable <= 4'h0;
      requantizerEnable <= 1'b0;
      rangeMonitorEnable <= 1'b0;
      quadratureEnable <= 1'b0;
      decimationFactor <= 4'h0;
      trimmedA <= '0;
      trimmedB <= '0;
    end else begin
      channelEnable <= next_channelEnable;
      requantizerEnable <= next_requantizerEnable;
      rangeMonitorEnable <= next_rangeMonitorEnable;
      quadratureEnable <= next_quadratureEnable;
      decimationFactor <= next_decimationFactor;
      trimmedA <= next_trimmedA;
      trimmedB <= next_trimmedB;
    end
  end

  // ------------------------------------------------------------
  // Threshold flag pins, one instance per channel
  // ------------------------------------------------------------
  logic [12:0] upperThreshold;
  assign upperThreshold = {upperHigh[4:0], upperLow};

  threshold_flag_channel #(.SAMPLE_W(SAMPLE_W)) flagA (
    .clk(clk),
    .srst(srst),
    .sample(sampleA),
    .upperThreshold(upperThreshold),
    .flagEnable(flagControl[rx_mode_pkg::FLAG_ENABLE_BIT]),
    .forcePins(flagControl[rx_mode_pkg::FORCE_PINS_BIT]),
    .forceValue(flagControl[rx_mode_pkg::FORCE_VALUE_BIT]),
    .flagPin(flagPinA)
  );

  threshold_flag_channel #(.SAMPLE_W(SAMPLE_W)) flagB (
    .clk(clk),
    .srst(srst),
    .sample(sampleB),
    .upperThreshold(upperThreshold),
    .flagEnable(flagControl[rx_mode_pkg::FLAG_ENABLE_BIT]),
    .forcePins(flagControl[rx_mode_pkg::FORCE_PINS_BIT]),
    .forceValue(flagControl[rx_mode_pkg::FORCE_VALUE_BIT]),
    .flagPin(flagPinB)
  );
endmodule

// ### bench/rx_mode_properties.sv
// Concurrent checks on the mode and detect register bank ports
`timescale 1ns/1ps
module rx_mode_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic syncCaptured,
  input wire logic [3:0] syncPhase,
  input wire logic [3:0] channelEnable,
  input wire logic requantizerEnable,
  input wire logic rangeMonitorEnable,
  input wire logic quadratureEnable,
  input wire logic [3:0] decimationFactor,
  input wire logic flagPinA,
  input wire logic flagPinB
);
  // ----------------------------------------
  // Shadow state and properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] cnt;
  logic [3:0] ph;
  // Shadow of capture count and phase, so reads can be judged
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 8'h00;
      ph <= 4'h0;
    end else if (syncCaptured) begin
      cnt <= cnt + 8'h01;
      ph <= syncPhase;
    end
  end
  // Lone write, then outputs one cycle after the register
  sequence wr(a);
    regWrite && regAddr == a ##1 !regWrite;
  endsequence
  function automatic logic [3:0] chanMap(input logic [3:0] m);
    return m == 4'h1 ? 4'h1 : m == 4'h2 ? 4'h3 : m == 4'h3 ? 4'hf : 4'h0;
  endfunction
  a_count_read: assert property (
    regRead && regAddr == 12'h12a |=> regRdData == $past(cnt))
    else $error("capture count read wrong");
  a_phase_read: assert property (
    regRead && regAddr == 12'h129 |=> regRdData == {4'h0, $past(ph)})
    else $error("capture phase read wrong");
  a_mode_channels: assert property (
    wr(12'h200) |=> channelEnable == chanMap($past(regWrData[3:0], 2)))
    else $error("channel enables wrong");
  a_mode_requant: assert property (
    wr(12'h200) |=> requantizerEnable == ($past(regWrData[3:0], 2) == 4'h7))
    else $error("requantizer enable wrong");
  a_mode_range: assert property (
    wr(12'h200) |=> rangeMonitorEnable == ($past(regWrData[3:0], 2) == 4'h8))
    else $error("range monitor enable wrong");
  a_quad_ignore: assert property (
    wr(12'h200) |=> quadratureEnable == !$past(regWrData[5], 2))
    else $error("quadrature enable wrong");
  a_decim_map: assert property (
    wr(12'h201) |=> decimationFactor ==
      ($past(regWrData[2], 2) ? 4'h1 : 4'h1 << $past(regWrData[1:0], 2)))
    else $error("decimation factor wrong");
  a_force_level: assert property (
    wr(12'h245) |=> !$past(regWrData[3], 2) ||
      (flagPinA == $past(regWrData[2], 2) && flagPinB == flagPinA))
    else $error("forced flag level wrong");
  a_read_idle: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data outside read slot");
  c_sync_burst: cover property (syncCaptured [*3]);
  c_force: cover property (wr(12'h245) ##0 $past(regWrData[3]));
  c_flag_split: cover property (flagPinA && !flagPinB);
endmodule

// ### bench/receiver_mode_and_detect_regs_tb.sv
// Self-checking bench for the receiver mode and detect register bank
`timescale 1ns/1ps
module receiver_mode_and_detect_regs_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic syncCaptured = 1'b0;
  logic [3:0] syncPhase = 4'h0;
  logic [7:0] syncWindow = 8'h5a;
  logic [13:0] sampleA = 14'h0000;
  logic [13:0] sampleB = 14'h0000;
  logic [7:0] regRdData, v;
  logic [13:0] trimmedA, trimmedB;
  logic [3:0] channelEnable, decimationFactor;
  logic requantizerEnable, rangeMonitorEnable, quadratureEnable, flagPinA, flagPinB;
  int nMismatch = 0;
  int cmpCount = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  receiver_mode_and_detect_regs receiver_mode_and_detect_regs_inst (.clk(clk), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .syncCaptured(syncCaptured), .syncPhase(syncPhase),
    .syncWindow(syncWindow), .sampleA(sampleA), .sampleB(sampleB), .trimmedA(trimmedA),
    .trimmedB(trimmedB), .channelEnable(channelEnable), .requantizerEnable(requantizerEnable),
    .rangeMonitorEnable(rangeMonitorEnable), .quadratureEnable(quadratureEnable),
    .decimationFactor(decimationFactor), .flagPinA(flagPinA), .flagPinB(flagPinB));
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    cmpCount++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobe is dropped at the taking edge, so calls never overlap
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    v = regRdData;
  endtask
  // Outputs trail the register by one edge; sample mid-cycle
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [11:0] zr [7] = '{12'h201, 12'h228, 12'h245, 12'h247, 12'h248, 12'h12a, 12'h300};
    rd(12'h200);
    chk("app mode", v, 16'h0007);
    chk("requantizer", requantizerEnable, 16'h1);
    chk("quadrature", quadratureEnable, 16'h1);
    chk("decimation", decimationFactor, 16'h1);
    wr(12'h12a, 8'hff);
    foreach (zr[i]) begin
      rd(zr[i]);
      chk("zero reg", v, 16'h0000);
    end
    rd(12'h128);
    chk("window", v, 16'h005a);
  endtask
  task automatic t_modes;
    logic [3:0] md [6] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h4};
    logic [3:0] ce [6] = '{4'h1, 4'h3, 4'hf, 4'h0, 4'h0, 4'h0};
    foreach (md[i]) begin
      wr(12'h200, {2'b00, i[0], 1'b0, md[i]});
      settle;
      chk("channels", channelEnable, ce[i]);
      chk("requantizer", requantizerEnable, md[i] == 4'h7);
      chk("range mon", rangeMonitorEnable, md[i] == 4'h8);
      chk("quadrature", quadratureEnable, !i[0]);
    end
    for (int d = 0; d < 5; d++) begin
      wr(12'h201, 8'(d));
      settle;
      chk("decimation", decimationFactor, d < 4 ? 16'h1 << d : 16'h1);
    end
  endtask
  task automatic t_sync;
    @(posedge clk);
    syncPhase <= 4'h5;
    syncCaptured <= 1'b1;
    repeat (3) @(posedge clk);
    syncCaptured <= 1'b0;
    rd(12'h12a);
    chk("count", v, 16'h0003);
    rd(12'h129);
    chk("phase", v, 16'h0005);
    @(posedge clk);
    syncCaptured <= 1'b1;
    repeat (253) @(posedge clk);
    syncCaptured <= 1'b0;
    rd(12'h12a);
    chk("count wrap", v, 16'h0000);
  endtask
  task automatic t_trim;
    wr(12'h228, 8'h80);
    sampleA <= 14'd100;
    sampleB <= 14'h3ffb;
    settle;
    chk("trim a", trimmedA, 16'h3fe4);
    chk("trim b", trimmedB, 16'h3f7b);
    wr(12'h228, 8'h7f);
    sampleA <= 14'h1fff;
    settle;
    chk("trim sat", trimmedA, 16'h1fff);
    chk("trim pos", trimmedB, 16'h007a);
  endtask
  // Threshold 0x1f00; A at 0x1fff sits above it, B at -5 below
  task automatic t_flags;
    wr(12'h248, 8'hff);
    wr(12'h245, 8'h01);
    settle;
    chk("flag a", flagPinA, 16'h1);
    chk("flag b", flagPinB, 16'h0);
    rd(12'h248);
    chk("thr high", v, 16'h001f);
    wr(12'h245, 8'hff);
    settle;
    chk("forced a", flagPinA, 16'h1);
    chk("forced b", flagPinB, 16'h1);
    rd(12'h245);
    chk("flag ctl", v, 16'h000d);
    wr(12'h245, 8'h09);
    settle;
    chk("forced low", {flagPinA, flagPinB}, 16'h0);
    wr(12'h245, 8'h00);
    settle;
    chk("flag off", flagPinA, 16'h0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      nMismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_modes;
    t_sync;
    t_trim;
    t_flags;
    end_of_test();
  end
endmodule
bind receiver_mode_and_detect_regs rx_mode_properties rx_mode_properties_inst (.clk(clk),
  .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .syncCaptured(syncCaptured),
  .syncPhase(syncPhase), .channelEnable(channelEnable), .requantizerEnable(requantizerEnable),
  .rangeMonitorEnable(rangeMonitorEnable), .quadratureEnable(quadratureEnable),
  .decimationFactor(decimationFactor), .flagPinA(flagPinA), .flagPinB(flagPinB));
